// File: core/rtcpx_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef RTCPX_CFG_SVH
`define RTCPX_CFG_SVH
`define RTCPX_OFS_CTRL_A      8'h4A
`define RTCPX_OFS_CTRL_B      8'h4B
`define RTCPX_OFS_XADDR_LO    8'h50
`define RTCPX_OFS_XADDR_HI    8'h51
`define RTCPX_OFS_XDATA       8'h53
`define RTCPX_A_UPDATE_BIT    6
`define RTCPX_A_BURST_BIT     5
`define RTCPX_A_POWEROFF_BIT  3
`define RTCPX_A_WIPEFLAG_BIT  2
`define RTCPX_A_WAKEFLAG_BIT  1
`define RTCPX_A_KICKFLAG_BIT  0
`define RTCPX_B_AUXBAT_BIT    7
`define RTCPX_B_OSCOUT_BIT    6
`define RTCPX_B_XTAL_BIT      5
`define RTCPX_B_WIPEEN_BIT    4
`define RTCPX_B_HOLDSEL_BIT   3
`define RTCPX_B_WIPEIE_BIT    2
`define RTCPX_B_WAKEEN_BIT    1
`define RTCPX_B_KICKEN_BIT    0
`define RTCPX_CTRL_A_RESET    8'h08
`define RTCPX_CTRL_B_RESET    8'h40
`define RTCPX_CLK_HZ          10000000
`define RTCPX_KICK_PULSE_NS   2000
`define RTCPX_KICK_PULSE_CYC  ((`RTCPX_KICK_PULSE_NS * (`RTCPX_CLK_HZ / 1000000) + 999) / 1000)
`define RTCPX_TIMEOUT_S       2
`define RTCPX_TIMEOUT_CYC     (`RTCPX_TIMEOUT_S * `RTCPX_CLK_HZ)
`define RTCPX_UPD_LEAD_US     122
`define RTCPX_UPD_LEAD_CYC    (`RTCPX_UPD_LEAD_US * (`RTCPX_CLK_HZ / 1000000))
`define RTCPX_RECOVER_CYC     16
`define RTCPX_USER_RAM_BYTES  114
`endif

// File: core/rtcpx_pkg.sv
// types shared by the extended power, wipe and extended-ram block
package rtcpx_pkg;
    typedef struct packed {
        logic       strobe;
        logic       write;
        logic       bank_select;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcpx_bus_req_type;
    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       refused;
    } rtcpx_bus_rsp_type;
    typedef struct packed {
        logic        write;
        logic [12:0] addr;
        logic [7:0]  data;
    } rtcpx_xram_req_type;
    typedef enum logic [1:0] {
        RTCPX_PWR_IDLE,
        RTCPX_PWR_WAIT,
        RTCPX_PWR_ON
    } rtcpx_pwr_state_type;
endpackage : rtcpx_pkg

// File: core/rtcpx_top.sv
// extended power control, user ram wipe and extended ram port of the clock
// What this block does
// [R1] power-on timeout of at least two seconds, only while oscillator runs
// [R2] timeout without main supply releases power request, interrupt stays off, flag kept
// [R3] writing zeros clears wake and kick flags, interrupt drops if nothing pending
// [R4] wake flag sets when date, hours, minutes, seconds match alarm
// [R5] kick flag sets on falling kick input lasting at least two microseconds
// [R6] with main power, enabled wake or kick flag drives interrupt low
// [R7] with main power, any enabled wake or kick event asserts power request
// [R8] power-off control bit three: zero drives request low, one floats it
// [R9] power-off bit auto-clears when an enabled wake or kick flag is set, except after a timeout until power returns or the flag clears
// [R10] interrupt output floats once supply is below the power-fail threshold
// [R11] host clears flags and sets enables before writing the power-off bit
// [R12] on power fail, hold-select one keeps request active, zero floats it
// [R13] enabled falling wipe input sets all 114 user ram bytes to ones
// [R14] wipe completion sets wipe flag, interrupt low if powered and enabled
// [R15] writing zero clears wipe flag, writing one sets it and interrupts
// [R16] bus accesses are refused for a recovery time after wipe input
// [R17] with wipe disabled the wipe input does nothing
// [R18] host sets address at 50h and 51h in bank one, data via 53h
// [R19] without burst the extended ram address stays put across accesses
// [R20] with burst the address steps after each access of 53h only
// [R21] update-pending bit sets 122us before each update and clears after it
// [R22] oscillator output enable drives 32k clock out, set at main power-up
// [R23] disabled wake or kick flag affects neither request nor interrupt
`timescale 1ns/1ps
`include "rtcpx_cfg.svh"

module rtcpx_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule : rtcpx_fifo

module rtcpx_top #(
    parameter int XRAM_AW     = 13,
    parameter int TIMEOUT_CYC = `RTCPX_TIMEOUT_CYC,
    parameter int FIFO_DEPTH  = 4
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_b_i,
    // host register access
    input  wire rtcpx_pkg::rtcpx_bus_req_type bus_req_i,
    output rtcpx_pkg::rtcpx_bus_rsp_type      bus_rsp_o,
    // status from the timekeeping core
    input  wire logic                        main_power_i,
    input  wire logic                        osc_running_i,
    input  wire logic                        alarm_match_i,
    input  wire logic                        update_start_i,
    input  wire logic                        update_end_i,
    input  wire logic                        osc_32k_i,
    // pins
    input  wire logic                        kick_input_n_i,
    input  wire logic                        user_ram_wipe_n_i,
    output logic                             power_request_n_o,
    output logic                             power_request_n_oe_o,
    output logic                             irq_n_o,
    output logic                             irq_n_oe_o,
    output logic                             square_wave_out_o,
    // user ram wipe
    output logic                             wipe_busy_o,
    output logic [6:0]                       wipe_addr_o,
    // extended ram write stream and read port
    output rtcpx_pkg::rtcpx_xram_req_type    xram_req_o,
    output logic                             xram_req_valid_o,
    input  wire logic                        xram_req_ready_i,
    input  wire logic [7:0]                  xram_rdata_i
);
    import rtcpx_pkg::*;

    localparam int KICK_CYC = `RTCPX_KICK_PULSE_CYC;
    localparam int LEAD_CYC = `RTCPX_UPD_LEAD_CYC;

    typedef struct packed {
        logic [2:0]          kick_sync;
        logic [2:0]          wipe_sync;
        logic [2:0]          pwr_sync;
        logic                kick_level;
        logic                wipe_level;
        logic                pwr_level;
        logic [7:0]          kick_cnt;
        logic                kick_done;
        logic [7:0]          ctrl_a;
        logic [7:0]          ctrl_b;
        logic [XRAM_AW-1:0]  xaddr;
        rtcpx_pwr_state_type pstate;
        logic [31:0]         timer;
        logic                request_active;
        logic                timed_out;
        logic                irq_active;
        logic [11:0]         lead_cnt;
        logic                lead_run;
        logic                wiping;
        logic [6:0]          wipe_ptr;
        logic [4:0]          lockout;
        logic                alarm_d;
        rtcpx_bus_rsp_type   rsp;
        logic                square_wave_out;
    } rtcpx_state_type;

    rtcpx_state_type s;
    rtcpx_state_type next_s;
    logic            fifo_in_ready;
    logic            fifo_push;
    logic [XRAM_AW+8:0] fifo_in;
    logic [XRAM_AW+8:0] fifo_out;

    // writes to 53h queue here so a slow ram stalls the host via refusal
    rtcpx_fifo #(.WIDTH(XRAM_AW + 9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (xram_req_valid_o),
        .out_ready_i (xram_req_ready_i),
        .out_data_o  (fifo_out)
    );
    assign xram_req_o = rtcpx_xram_req_type'({fifo_out[XRAM_AW+8], 13'(fifo_out[XRAM_AW+7:8]),
                                              fifo_out[7:0]});

    logic hit;
    logic wr;
    logic rd;
    logic wake_on;
    logic kick_on;
    logic wipe_fall;
    logic wipe_fall_ok;
    logic power_fall;

    always_comb begin
        next_s = s;
        next_s.kick_sync = {s.kick_sync[1:0], kick_input_n_i};
        next_s.wipe_sync = {s.wipe_sync[1:0], user_ram_wipe_n_i};
        next_s.pwr_sync  = {s.pwr_sync[1:0], main_power_i};
        if (s.kick_sync[2] == s.kick_sync[1]) next_s.kick_level = s.kick_sync[2];
        if (s.wipe_sync[2] == s.wipe_sync[1]) next_s.wipe_level = s.wipe_sync[2];
        if (s.pwr_sync[2] == s.pwr_sync[1])   next_s.pwr_level  = s.pwr_sync[2];
        next_s.alarm_d = alarm_match_i;
        next_s.rsp     = '0;
        next_s.square_wave_out     = osc_32k_i && s.ctrl_b[`RTCPX_B_OSCOUT_BIT]; // [R22]
        wipe_fall    = s.wipe_level && !next_s.wipe_level;
        wipe_fall_ok = wipe_fall && s.ctrl_b[`RTCPX_B_WIPEEN_BIT]; // [R17]
        power_fall   = s.pwr_level && !next_s.pwr_level;

        if (s.kick_level) begin
            next_s.kick_cnt  = '0;
            next_s.kick_done = 1'b0;
        end else if (!s.kick_done && s.kick_cnt < 8'(KICK_CYC - 1)) begin
            next_s.kick_cnt = s.kick_cnt + 8'd1;
        end else if (!s.kick_done) begin
            next_s.kick_done = 1'b1;
        end

        hit = bus_req_i.strobe && bus_req_i.bank_select; // [R18]
        wr  = hit && bus_req_i.write;
        rd  = hit && !bus_req_i.write;
        if (hit) begin
            next_s.rsp.valid = 1'b1;
            if (s.lockout != '0 || s.wiping ||
                (wr && bus_req_i.addr == `RTCPX_OFS_XDATA && !fifo_in_ready)) begin
                next_s.rsp.refused = 1'b1; // [R16]
                wr = 1'b0;
                rd = 1'b0;
            end
        end
        fifo_push = wr && bus_req_i.addr == `RTCPX_OFS_XDATA;
        fifo_in   = {1'b1, s.xaddr, bus_req_i.wdata};
        if (rd) begin
            unique case (bus_req_i.addr)
                `RTCPX_OFS_CTRL_A:   next_s.rsp.rdata = s.ctrl_a;
                `RTCPX_OFS_CTRL_B:   next_s.rsp.rdata = s.ctrl_b;
                `RTCPX_OFS_XADDR_LO: next_s.rsp.rdata = s.xaddr[7:0];
                `RTCPX_OFS_XADDR_HI: next_s.rsp.rdata = 8'(s.xaddr[XRAM_AW-1:8]);
                `RTCPX_OFS_XDATA:    next_s.rsp.rdata = xram_rdata_i;
                default:             next_s.rsp.rdata = 8'h00;
            endcase
        end
        if (wr) begin
            unique case (bus_req_i.addr)
                `RTCPX_OFS_CTRL_A: begin
                    // bit 6 stays hardware owned; flags follow the written value
                    next_s.ctrl_a[5:0] = bus_req_i.wdata[5:0]; // [R3] [R8] [R15]
                end
                `RTCPX_OFS_CTRL_B:   next_s.ctrl_b = bus_req_i.wdata;
                `RTCPX_OFS_XADDR_LO: next_s.xaddr[7:0] = bus_req_i.wdata;
                `RTCPX_OFS_XADDR_HI: next_s.xaddr[XRAM_AW-1:8] = bus_req_i.wdata[XRAM_AW-9:0];
                default: ;
            endcase
        end
        if ((rd || wr) && bus_req_i.addr == `RTCPX_OFS_XDATA &&
            s.ctrl_a[`RTCPX_A_BURST_BIT]) begin
            next_s.xaddr = s.xaddr + XRAM_AW'(1); // [R19] [R20]
        end

        // hardware sets win over a software clear in the same cycle
        if (s.kick_level == 1'b0 && !s.kick_done && s.kick_cnt == 8'(KICK_CYC - 1)) begin
            next_s.ctrl_a[`RTCPX_A_KICKFLAG_BIT] = 1'b1; // [R5]
        end
        if (alarm_match_i && !s.alarm_d) begin
            next_s.ctrl_a[`RTCPX_A_WAKEFLAG_BIT] = 1'b1; // [R4]
        end

        if (wipe_fall_ok && !s.wiping) begin
            next_s.wiping   = 1'b1; // [R13]
            next_s.wipe_ptr = '0;
            next_s.lockout  = 5'(`RTCPX_RECOVER_CYC); // [R16]
        end else if (s.wiping) begin
            if (s.wipe_ptr == 7'(`RTCPX_USER_RAM_BYTES - 1)) begin
                next_s.wiping = 1'b0;
                next_s.ctrl_a[`RTCPX_A_WIPEFLAG_BIT] = 1'b1; // [R14]
            end else begin
                next_s.wipe_ptr = s.wipe_ptr + 7'd1;
            end
        end else if (s.lockout != '0) begin
            next_s.lockout = s.lockout - 5'd1;
        end

        wake_on = next_s.ctrl_a[`RTCPX_A_WAKEFLAG_BIT] && s.ctrl_b[`RTCPX_B_WAKEEN_BIT]; // [R23]
        kick_on = next_s.ctrl_a[`RTCPX_A_KICKFLAG_BIT] && s.ctrl_b[`RTCPX_B_KICKEN_BIT]; // [R23]
        if ((wake_on || kick_on) && !s.timed_out) begin
            next_s.ctrl_a[`RTCPX_A_POWEROFF_BIT] = 1'b0; // [R9]
        end
        if (s.pwr_level || !(wake_on || kick_on)) next_s.timed_out = 1'b0;
        unique case (s.pstate)
            RTCPX_PWR_IDLE: begin
                if ((wake_on || kick_on) && !s.pwr_level && !s.timed_out) begin
                    next_s.pstate = RTCPX_PWR_WAIT;
                    next_s.timer  = '0;
                end else if (s.pwr_level) begin
                    next_s.pstate = RTCPX_PWR_ON;
                end
            end
            RTCPX_PWR_WAIT: begin
                if (s.pwr_level) begin
                    next_s.pstate = RTCPX_PWR_ON;
                end else if (osc_running_i) begin
                    if (s.timer >= 32'(TIMEOUT_CYC - 1)) begin
                        next_s.pstate = RTCPX_PWR_IDLE; // [R1] [R2]
                        next_s.timed_out = 1'b1; // [R2]
                        next_s.ctrl_a[`RTCPX_A_POWEROFF_BIT] = 1'b1; // [R2]
                    end else begin
                        next_s.timer = s.timer + 32'd1; // [R1]
                    end
                end
            end
            RTCPX_PWR_ON: begin
                if (power_fall) begin
                    next_s.pstate = RTCPX_PWR_IDLE;
                    if (!s.ctrl_b[`RTCPX_B_HOLDSEL_BIT]) begin
                        next_s.ctrl_a[`RTCPX_A_POWEROFF_BIT] = 1'b1; // [R12]
                    end
                end
            end
        endcase
        if (!s.pwr_level && next_s.pwr_level) begin
            next_s.ctrl_b[`RTCPX_B_OSCOUT_BIT] = 1'b1; // [R22]
        end
        if (s.pstate == RTCPX_PWR_WAIT && next_s.pstate == RTCPX_PWR_IDLE) begin
            next_s.request_active = 1'b0; // [R2]
        end else begin
            next_s.request_active = !next_s.ctrl_a[`RTCPX_A_POWEROFF_BIT]; // [R7] [R8]
        end
        next_s.irq_active = next_s.pwr_level && (wake_on || kick_on ||
            (next_s.ctrl_a[`RTCPX_A_WIPEFLAG_BIT] && s.ctrl_b[`RTCPX_B_WIPEIE_BIT])); // [R6] [R10] [R14]

        if (update_end_i) begin
            next_s.ctrl_a[`RTCPX_A_UPDATE_BIT] = 1'b0; // [R21]
            next_s.lead_run = 1'b0;
        end else if (update_start_i) begin
            next_s.lead_run = 1'b1;
            next_s.lead_cnt = '0;
        end else if (s.lead_run) begin
            if (s.lead_cnt == 12'(LEAD_CYC - 1)) begin
                next_s.ctrl_a[`RTCPX_A_UPDATE_BIT] = 1'b1; // [R21]
            end else begin
                next_s.lead_cnt = s.lead_cnt + 12'd1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s        <= '0;
            s.kick_sync  <= 3'b111;
            s.wipe_sync  <= 3'b111;
            s.kick_level <= 1'b1;
            s.wipe_level <= 1'b1;
            s.ctrl_a <= `RTCPX_CTRL_A_RESET;
            s.ctrl_b <= `RTCPX_CTRL_B_RESET;
            s.pstate <= RTCPX_PWR_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign bus_rsp_o            = s.rsp;
    assign power_request_n_o    = 1'b0;
    assign power_request_n_oe_o = !s.request_active;
    assign irq_n_o              = 1'b0;
    assign irq_n_oe_o           = !s.irq_active;
    assign square_wave_out_o    = s.square_wave_out;
    assign wipe_busy_o          = s.wiping;
    assign wipe_addr_o          = s.wipe_ptr;
endmodule : rtcpx_top

// File: test/rtcpx_props.sv
// concurrent checks on the top-level ports of the power and ram block
`timescale 1ns/1ps
module rtcpx_props #(
    parameter int TIMEOUT_CYC = 50
) (
    // clock and reset
    input wire logic                         clk_i,
    input wire logic                         rst_b_i,
    // host bus
    input wire rtcpx_pkg::rtcpx_bus_req_type bus_req_i,
    input wire rtcpx_pkg::rtcpx_bus_rsp_type bus_rsp_o,
    // status and pins
    input wire logic                         main_power_i,
    input wire logic                         osc_32k_i,
    input wire logic                         power_request_n_oe_o,
    input wire logic                         irq_n_oe_o,
    input wire logic                         square_wave_out_o,
    input wire logic                         wipe_busy_o,
    input wire logic [6:0]                   wipe_addr_o,
    input wire logic                         xram_req_valid_o
);
    import rtcpx_pkg::*;
    logic [7:0]  busy_cnt;
    logic [31:0] off_cnt;
    logic        sel;
    assign sel = bus_req_i.strobe & bus_req_i.bank_select;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_cnt <= 8'h00;
            off_cnt  <= 32'h0000_0000;
        end else begin
            busy_cnt <= wipe_busy_o ? busy_cnt + 8'h01 : 8'h00;
            off_cnt  <= (!power_request_n_oe_o && !main_power_i) ? off_cnt + 32'h0000_0001 : '0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rsp_taken;
        sel |=> bus_rsp_o.valid;
    endproperty
    a_rsp_taken: assert property (p_rsp_taken) else $error("access not answered");
    property p_rsp_idle;
        !sel |=> !bus_rsp_o.valid;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without access");
    property p_refuse_busy;
        wipe_busy_o && sel |=> bus_rsp_o.refused;
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("access taken in wipe");
    property p_irq_unpowered;
        !main_power_i [*6] |-> irq_n_oe_o;
    endproperty
    a_irq_unpowered: assert property (p_irq_unpowered) else $error("irq driven unpowered");
    property p_wipe_len;
        $fell(wipe_busy_o) |-> busy_cnt == 8'h72;
    endproperty
    a_wipe_len: assert property (p_wipe_len) else $error("wipe length wrong");
    property p_wipe_addr;
        wipe_busy_o |-> wipe_addr_o < 7'h72;
    endproperty
    a_wipe_addr: assert property (p_wipe_addr) else $error("wipe index out of range");
    property p_xram_push;
        bus_rsp_o.valid && !bus_rsp_o.refused && $past(bus_req_i.write)
            && $past(bus_req_i.addr) == 8'h53 |-> xram_req_valid_o;
    endproperty
    a_xram_push: assert property (p_xram_push) else $error("data write not queued");
    property p_timeout;
        $rose(power_request_n_oe_o) && off_cnt > 32'h0000_0008 |-> off_cnt >= TIMEOUT_CYC;
    endproperty
    a_timeout: assert property (p_timeout) else $error("request released early");
    property p_sqw;
        square_wave_out_o |-> $past(osc_32k_i);
    endproperty
    a_sqw: assert property (p_sqw) else $error("square wave not from oscillator");
endmodule : rtcpx_props

bind rtcpx_top rtcpx_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) rtcpx_props_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req_i), .bus_rsp_o(bus_rsp_o),
    .main_power_i(main_power_i), .osc_32k_i(osc_32k_i),
    .power_request_n_oe_o(power_request_n_oe_o), .irq_n_oe_o(irq_n_oe_o),
    .square_wave_out_o(square_wave_out_o), .wipe_busy_o(wipe_busy_o),
    .wipe_addr_o(wipe_addr_o), .xram_req_valid_o(xram_req_valid_o)
);

// File: test/rtcpx_host.sv
// host processor model driving the bank-one register bus
`timescale 1ns/1ps
module rtcpx_host (
    // clock
    input  wire logic                         clk_i,
    // register bus
    output rtcpx_pkg::rtcpx_bus_req_type      bus_req_o,
    input  wire rtcpx_pkg::rtcpx_bus_rsp_type bus_rsp_i
);
    import rtcpx_pkg::*;
    initial bus_req_o = '0;
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic rf);
        @(posedge clk_i);
        #10;
        bus_req_o = '{strobe: 1'b1, write: w, bank_select: 1'b1, addr: a, wdata: d};
        @(posedge clk_i);
        #10;
        q = bus_rsp_i.rdata;
        rf = bus_rsp_i.refused | ~bus_rsp_i.valid;
        bus_req_o.strobe = 1'b0;
        bus_req_o.addr = ~a;
        bus_req_o.wdata = ~d;
    endtask : access
endmodule : rtcpx_host

// File: test/rtc_power_ramclear_extram_bench.sv
// self-checking bench for the power, wipe and extended-ram block
`timescale 1ns/1ps
module rtc_power_ramclear_extram_bench;
    import rtcpx_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, power_request_n = 1'b1, osc = 1'b1, alarm = 1'b0;
    logic ustart = 1'b0, uend = 1'b0, o32 = 1'b0, kick_n = 1'b1, wipe_n = 1'b1;
    logic req_oe, irq_oe, square_wave_out, busy, xvalid, xready = 1'b0, rf, s;
    logic [7:0] q;
    rtcpx_bus_req_type  breq;
    rtcpx_bus_rsp_type  brsp;
    rtcpx_xram_req_type xreq;
    rtcpx_xram_req_type popped[$];
    int fails = 0, n_checks = 0, cycles = 0;
    rtcpx_host rtcpx_host_inst (.clk_i(clk_i), .bus_req_o(breq), .bus_rsp_i(brsp));
    rtcpx_top #(.TIMEOUT_CYC(50)) rtcpx_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_req_i(breq), .bus_rsp_o(brsp),
        .main_power_i(power_request_n), .osc_running_i(osc), .alarm_match_i(alarm),
        .update_start_i(ustart), .update_end_i(uend), .osc_32k_i(o32),
        .kick_input_n_i(kick_n), .user_ram_wipe_n_i(wipe_n), .power_request_n_o(),
        .power_request_n_oe_o(req_oe), .irq_n_o(), .irq_n_oe_o(irq_oe),
        .square_wave_out_o(square_wave_out), .wipe_busy_o(busy), .wipe_addr_o(),
        .xram_req_o(xreq), .xram_req_valid_o(xvalid), .xram_req_ready_i(xready),
        .xram_rdata_i(8'h5A));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) o32 <= #10 ~o32;
    always @(posedge clk_i) begin
        if (xvalid && xready) popped.push_back(xreq);
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(string n, logic [15:0] sv, logic [15:0] e);
        n_checks++;
        if (sv !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, sv);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask : cyc
    task automatic wr(logic [7:0] a, logic [7:0] d);
        rtcpx_host_inst.access(1'b1, a, d, q, rf);
    endtask : wr
    task automatic rd(string n, logic [7:0] a, logic [7:0] m, logic [7:0] e);
        rtcpx_host_inst.access(1'b0, a, 8'h00, q, rf);
        chk(n, {8'h00, q & m}, {8'h00, e});
    endtask : rd
    task automatic pin(string n, int c, ref logic p, input logic e);
        cyc(c);
        chk(n, p, e);
    endtask : pin
    task automatic kick(int n);
        kick_n = 1'b0;
        cyc(n);
        kick_n = 1'b1;
    endtask : kick
    task automatic t_regs;
        pin("req_oe", 0, req_oe, 1'b1);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h08);
        rd("ctrl_b", 8'h4B, 8'hFF, 8'h40);
        rd("unmapped", 8'h52, 8'hFF, 8'h00);
        wr(8'h4A, 8'hD8);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h18);
        wr(8'h4A, 8'h00);
        pin("req_oe", 2, req_oe, 1'b0);
        wr(8'h4A, 8'h08);
        pin("req_oe", 2, req_oe, 1'b1);
        s = square_wave_out;
        pin("sqw", 1, square_wave_out, !s);
        wr(8'h4B, 8'h00);
        pin("sqw", 3, square_wave_out, 1'b0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_kick;
        wr(8'h4B, 8'h41);
        kick(30);
        pin("irq_oe", 5, irq_oe, 1'b0);
        pin("req_oe", 0, req_oe, 1'b0);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h01);
        wr(8'h4A, 8'h00);
        pin("irq_oe", 2, irq_oe, 1'b1);
        kick(5);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h00);
        wr(8'h4B, 8'h40);
        wr(8'h4A, 8'h08);
        kick(30);
        pin("irq_oe", 5, irq_oe, 1'b1);
        pin("req_oe", 0, req_oe, 1'b1);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h09);
        wr(8'h4B, 8'h42);
        wr(8'h4A, 8'h08);
        alarm = 1'b1;
        pin("irq_oe", 5, irq_oe, 1'b0);
        alarm = 1'b0;
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h02);
        power_request_n = 1'b0;
        pin("irq_oe", 8, irq_oe, 1'b1);
        power_request_n = 1'b1;
        $display("test kick and wake done");
    endtask : t_kick
    task automatic t_power;
        wr(8'h4B, 8'h41);
        wr(8'h4A, 8'h08);
        power_request_n = 1'b0;
        osc = 1'b0;
        cyc(8);
        kick(30);
        cyc(100);
        osc = 1'b1;
        pin("req_oe", 30, req_oe, 1'b0);
        pin("req_oe", 40, req_oe, 1'b1);
        pin("irq_oe", 0, irq_oe, 1'b1);
        power_request_n = 1'b1;
        cyc(5);
        rd("kick_flag", 8'h4A, 8'h01, 8'h01);
        wr(8'h4B, 8'h49);
        wr(8'h4A, 8'h00);
        power_request_n = 1'b0;
        pin("req_oe", 8, req_oe, 1'b0);
        power_request_n = 1'b1;
        cyc(5);
        wr(8'h4B, 8'h41);
        power_request_n = 1'b0;
        pin("req_oe", 8, req_oe, 1'b1);
        power_request_n = 1'b1;
        $display("test power done");
    endtask : t_power
    task automatic t_wipe;
        wr(8'h4B, 8'h54);
        wipe_n = 1'b0;
        cyc(10);
        wipe_n = 1'b1;
        rd("refused", 8'h4A, 8'h00, 8'h00);
        chk("refused", rf, 1'b1);
        for (int i = 0; i < 200 && busy; i++) cyc(1);
        rd("refused", 8'h4A, 8'h00, 8'h00);
        chk("lockout", rf, 1'b1);
        cyc(16);
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h0C);
        chk("irq_oe", irq_oe, 1'b0);
        wr(8'h4A, 8'h08);
        pin("irq_oe", 2, irq_oe, 1'b1);
        wr(8'h4A, 8'h0C);
        pin("irq_oe", 2, irq_oe, 1'b0);
        wr(8'h4A, 8'h08);
        wr(8'h4B, 8'h40);
        wipe_n = 1'b0;
        pin("busy", 10, busy, 1'b0);
        wipe_n = 1'b1;
        rd("ctrl_a", 8'h4A, 8'hFF, 8'h08);
        $display("test wipe done");
    endtask : t_wipe
    task automatic t_xram;
        wr(8'h4A, 8'h28);
        wr(8'h50, 8'hFE);
        wr(8'h51, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(8'h53, 8'h11 + 8'(i));
            chk("fifo refuse", rf, i == 4);
        end
        xready = 1'b1;
        cyc(8);
        chk("drained", 16'(popped.size()), 16'h0004);
        for (int i = 0; i < 4; i++) begin
            chk("burst addr", 16'(popped[i].addr), 16'h01FE + 16'(i));
            chk("burst data", 16'(popped[i].data), 16'h0011 + 16'(i));
        end
        popped.delete();
        wr(8'h4A, 8'h08);
        wr(8'h53, 8'h21);
        rd("xram read", 8'h53, 8'hFF, 8'h5A);
        wr(8'h53, 8'h22);
        cyc(4);
        chk("held addr", 16'(popped[0].addr), 16'h0202);
        chk("held addr", 16'(popped[1].addr), 16'h0202);
        $display("test xram done");
    endtask : t_xram
    task automatic t_update;
        ustart = 1'b1;
        cyc(1);
        ustart = 1'b0;
        cyc(1190);
        rd("pending", 8'h4A, 8'h40, 8'h00);
        cyc(35);
        rd("pending", 8'h4A, 8'h40, 8'h40);
        uend = 1'b1;
        cyc(1);
        uend = 1'b0;
        rd("pending", 8'h4A, 8'h40, 8'h00);
        $display("test update done");
    endtask : t_update
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(3);
        rst_b_i = 1'b1;
        cyc(5);
        t_regs();
        t_kick();
        t_power();
        t_wipe();
        t_xram();
        t_update();
        tally_and_finish();
    end
endmodule : rtc_power_ramclear_extram_bench
